/* pkg/dcs_regs.svh */
// timing, geometry and capacity constants of the compose scheduler
`ifndef DCS_REGS_SVH
`define DCS_REGS_SVH

`define DCS_CLK_MHZ         100
`define DCS_FRAME_PERIOD_US 16660
`define DCS_FRAME_CYC_W     21
`define DCS_BLK_W           512
`define DCS_BLK_W_BITS      10
`define DCS_X_W             13
`define DCS_Y_W             12
`define DCS_IDX_W           4
`define DCS_LAYER_W         4
`define DCS_OV_CAP_WIDE     4'h8
`define DCS_OV_CAP_NARROW   4'h2
`define DCS_OV_NARROW_SEL   2'h3
`define DCS_MIN_LAYER_X     13'h004
`define DCS_MIN_LAYER_Y     12'h004
`define DCS_FIFO_DEPTH      16

`endif

/* pkg/dcs_pkg.sv */
// types shared by the compose scheduler, its checkers and its bench
`include "dcs_regs.svh"

package dcs_pkg;

    // scheduler states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EMIT = 2'b01
    } sched_e;

    // one accepted task as the scheduler keeps it
    typedef struct packed {
        logic [`DCS_X_W-1:0] width;
        logic [`DCS_Y_W-1:0] y0;
        logic [`DCS_Y_W-1:0] rows;
        logic                offline;
    } task_s;

    // one block descriptor sent toward the read and write-back channels
    typedef struct packed {
        logic                       offline;
        logic                       last;
        logic [`DCS_IDX_W-1:0]      idx;
        logic [`DCS_X_W-1:0]        x_base;
        logic [`DCS_BLK_W_BITS-1:0] width;
        logic [`DCS_Y_W-1:0]        y0;
        logic [`DCS_Y_W-1:0]        rows;
    } desc_s;

endpackage

/* src/dcs_fifo.sv */
// block descriptor fifo with a registered output stage
`timescale 1ns/1ps
`default_nettype none

module dcs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    // whole fifo state; capacity is DEPTH words plus the output stage
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
        logic                        ovld;
        logic [WIDTH-1:0]            odat;
    } fifo_s;

    fifo_s q;   // registered state
    fifo_s d;   // next state
    logic  push;  // word enters the array
    logic  pop;   // word moves into the output stage

    // honest full: ready drops only when the array is really full
    assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
    assign out_valid = q.ovld;
    assign out_data  = q.odat;

    // next state: write, refill output stage when it empties or drains
    always_comb begin
        d    = q;
        push = in_valid && in_ready;
        pop  = (q.cnt != '0) && (!q.ovld || out_ready);
        if (out_ready) begin
            d.ovld = 1'b0;  // consumed unless refilled below
        end
        if (push) begin
            d.mem[q.wr] = in_data;
            d.wr        = q.wr + 1'b1;
        end
        if (pop) begin
            d.odat = q.mem[q.rd];
            d.ovld = 1'b1;
            d.rd   = q.rd + 1'b1;
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

`default_nettype wire

/* src/display_compose_scheduler.sv */
// frame scheduler and vertical block partitioner for display composition
// Operation
// - register-bus reset release synchronised to its domain
// - memory-bus reset release synchronised to its domain
// - main active-low reset clears composition logic
// - video mode vsync each 16.66 ms always
// - run pending task, else repeat previous one
// - command mode refreshes on request, partial region
// - offline output cut into 512-pixel vertical blocks
// - each block origin is its upper-left corner
// - compositors take eight layers, last one two
// - every layer at least 4 wide, 4 high
// - write-back never scales; size set before write-back
`include "dcs_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module display_compose_scheduler
    import dcs_pkg::*;
#(
    // frame period in core cycles; shorten in simulation
    parameter int unsigned FRAME_CYCLES = `DCS_FRAME_PERIOD_US * `DCS_CLK_MHZ
) (
    input  wire logic                        REF_CLK,
    input  wire logic                        NRST,
    input  wire logic                        RST_REGBUS_N,
    input  wire logic                        RST_MEMBUS_N,
    output logic                             RST_REGBUS_SYNC_N,
    output logic                             RST_MEMBUS_SYNC_N,
    input  wire logic                        MODE_CMD,
    input  wire logic                        REFRESH_REQ,
    input  wire logic                        TASK_VALID,
    output logic                             TASK_READY,
    input  wire logic [`DCS_X_W-1:0]         TASK_WIDTH,
    input  wire logic [`DCS_Y_W-1:0]         TASK_HEIGHT,
    input  wire logic [`DCS_Y_W-1:0]         TASK_Y0,
    input  wire logic [`DCS_Y_W-1:0]         TASK_ROWS,
    input  wire logic                        TASK_OFFLINE,
    input  wire logic [1:0]                  TASK_COMP,
    input  wire logic [`DCS_LAYER_W-1:0]     TASK_LAYERS,
    input  wire logic [`DCS_X_W-1:0]         TASK_MIN_W,
    input  wire logic [`DCS_Y_W-1:0]         TASK_MIN_H,
    output logic                             TASK_REJECT,
    output logic                             VSYNC,
    output logic                             FRAME_BUSY,
    output logic                             FRAME_SKIP,
    output logic                             BLK_VALID,
    input  wire logic                        BLK_READY,
    output dcs_pkg::desc_s                   BLK_DATA
);

    // whole scheduler state
    typedef struct packed {
        sched_e                     state;     // fsm
        logic [`DCS_FRAME_CYC_W-1:0] timer;    // video frame timer
        logic                       vsync;     // frame start pulse
        logic                       pend_vld;  // new task waiting
        task_s                      pend;      // new task
        logic                       cur_vld;   // a task has run before
        task_s                      cur;       // task being repeated
        logic [`DCS_X_W-1:0]        x;         // next block's left edge
        logic [`DCS_IDX_W-1:0]      idx;       // next block number
        logic                       reject;    // task refused pulse
        logic                       skip;      // frame missed pulse
        logic                       ready;     // no task pending, to port
        logic                       busy;      // blocks being emitted
    } sched_s;

    sched_s q;                  // registered state
    sched_s d;                  // next state
    logic   core_s1_q;          // core reset synchroniser, first flop
    logic   core_rst_n;         // core reset, synchronous release
    logic   rb_s1_q;            // register-bus synchroniser, first flop
    logic   rb_s2_q;            // register-bus synchronised reset
    logic   mb_s1_q;            // memory-bus synchroniser, first flop
    logic   mb_s2_q;            // memory-bus synchronised reset
    logic   frame_start;        // a refresh is due this cycle
    logic   task_ok;            // offered task passes the checks
    logic   fifo_in_ready;      // fifo can take a descriptor
    desc_s  desc;               // descriptor being offered
    logic [`DCS_X_W-1:0] rem;   // pixels still to cover

    // layer capacity of the selected compositor, base layer not counted
    function automatic logic [`DCS_LAYER_W-1:0] ov_cap(
        input logic [1:0] sel
    );
        if (sel == `DCS_OV_NARROW_SEL) begin
            ov_cap = `DCS_OV_CAP_NARROW;
        end else begin
            ov_cap = `DCS_OV_CAP_WIDE;
        end
    endfunction

    // core reset: async assert, release after two edges
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            core_s1_q  <= 1'b0;
            core_rst_n <= 1'b0;
        end else begin
            core_s1_q  <= 1'b1;
            core_rst_n <= core_s1_q;
        end
    end

    // register-bus reset; both buses share the one clock here
    always_ff @(posedge REF_CLK or negedge RST_REGBUS_N) begin
        if (!RST_REGBUS_N) begin
            rb_s1_q <= 1'b0;
            rb_s2_q <= 1'b0;
        end else begin
            rb_s1_q <= 1'b1;
            rb_s2_q <= rb_s1_q;
        end
    end

    // memory-bus reset synchroniser
    always_ff @(posedge REF_CLK or negedge RST_MEMBUS_N) begin
        if (!RST_MEMBUS_N) begin
            mb_s1_q <= 1'b0;
            mb_s2_q <= 1'b0;
        end else begin
            mb_s1_q <= 1'b1;
            mb_s2_q <= mb_s1_q;
        end
    end

    assign RST_REGBUS_SYNC_N = rb_s2_q;
    assign RST_MEMBUS_SYNC_N = mb_s2_q;
    assign TASK_READY        = q.ready;
    assign TASK_REJECT       = q.reject;
    assign VSYNC             = q.vsync;
    assign FRAME_SKIP        = q.skip;

    // busy flag straight from its own state flop
    assign FRAME_BUSY        = q.busy;

    // descriptor of the block at the current edge
    always_comb begin
        rem         = q.cur.width - q.x;
        desc        = '0;
        desc.offline = q.cur.offline;
        desc.idx    = q.idx;
        desc.x_base = q.x;      // block origin, layers offset from it
        desc.y0     = q.cur.y0;
        desc.rows   = q.cur.rows;
        if (q.cur.offline && (rem > `DCS_X_W'(`DCS_BLK_W))) begin
            desc.width = `DCS_BLK_W_BITS'(`DCS_BLK_W);
            desc.last  = 1'b0;
        end else if (q.cur.offline) begin
            desc.width = rem[`DCS_BLK_W_BITS-1:0];
            desc.last  = 1'b1;
        end else begin
            // online: one block; width field holds low bits, x covers all
            desc.width = rem[`DCS_BLK_W_BITS-1:0];
            desc.last  = 1'b1;
        end
    end

    // task checks: capacity and smallest layer size
    always_comb begin
        task_ok = (TASK_LAYERS <= ov_cap(TASK_COMP))
               && (TASK_MIN_W >= `DCS_MIN_LAYER_X)
               && (TASK_MIN_H >= `DCS_MIN_LAYER_Y)
               && (TASK_WIDTH != '0);
    end

    // frame trigger: timer wrap in video mode, request in command mode
    always_comb begin
        if (MODE_CMD) begin
            frame_start = REFRESH_REQ;
        end else begin
            frame_start = (q.timer == `DCS_FRAME_CYC_W'(FRAME_CYCLES - 1));
        end
    end

    // scheduler next state
    always_comb begin
        d        = q;
        d.vsync  = 1'b0;
        d.reject = 1'b0;
        d.skip   = 1'b0;

        // free-running frame timer; held at zero for command screens
        if (MODE_CMD || frame_start) begin
            d.timer = '0;
        end else begin
            d.timer = q.timer + 1'b1;
        end

        // accept a task only while none is pending
        if (TASK_VALID && !q.pend_vld) begin
            if (task_ok) begin
                d.pend_vld     = 1'b1;
                d.pend.width   = TASK_WIDTH;
                d.pend.offline = TASK_OFFLINE;
                if (MODE_CMD) begin
                    d.pend.y0   = TASK_Y0;
                    d.pend.rows = TASK_ROWS;
                end else begin
                    d.pend.y0   = '0;
                    d.pend.rows = TASK_HEIGHT;
                end
            end else begin
                d.reject = 1'b1;
            end
        end

        case (q.state)
            ST_IDLE: begin
                if (frame_start) begin
                    d.vsync = 1'b1;
                    d.x     = '0;
                    d.idx   = '0;
                    if (q.pend_vld) begin
                        // newest task wins; ready was low so none is lost
                        d.cur      = q.pend;
                        d.cur_vld  = 1'b1;
                        d.pend_vld = 1'b0;
                        d.state    = ST_EMIT;
                    end else if (q.cur_vld) begin
                        d.state = ST_EMIT;
                    end
                end
            end
            ST_EMIT: begin
                // a trigger while blocks drain misses that frame
                if (frame_start) begin
                    d.vsync = !MODE_CMD;
                    d.skip  = 1'b1;
                end
                if (fifo_in_ready) begin
                    d.x   = q.x + `DCS_X_W'(desc.width);
                    d.idx = q.idx + 1'b1;
                    if (desc.last) begin
                        d.state = ST_IDLE;
                    end
                end
            end
            default: begin
                d.state = ST_IDLE;
            end
        endcase

        // port copies kept in flops so no output leaves through gates
        d.ready = !d.pend_vld;
        d.busy  = (d.state == ST_EMIT);
    end

    // state register on the synchronised core reset
    always_ff @(posedge REF_CLK or negedge core_rst_n) begin
        if (!core_rst_n) begin
            q       <= '0;
            q.state <= ST_IDLE;
            q.ready <= 1'b1;    // nothing pending while in reset
        end else begin
            q <= d;
        end
    end

    // descriptor buffer; a stalled consumer stalls the partitioner
    dcs_fifo #(
        .WIDTH ($bits(desc_s)),
        .DEPTH (`DCS_FIFO_DEPTH)
    ) u_fifo (
        .clk       (REF_CLK),
        .rst_n     (core_rst_n),
        .in_valid  (q.state == ST_EMIT),
        .in_ready  (fifo_in_ready),
        .in_data   (desc),
        .out_valid (BLK_VALID),
        .out_ready (BLK_READY),
        .out_data  (BLK_DATA)
    );

endmodule

`default_nettype wire

/* verif/display_compose_scheduler_asserts.sv */
// port-level checks of the compose scheduler
`include "dcs_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module display_compose_scheduler_asserts #(
    parameter int FRAME_CYCLES = 200
) (
    input wire logic                    REF_CLK,
    input wire logic                    NRST,
    input wire logic                    RST_REGBUS_N,
    input wire logic                    RST_MEMBUS_N,
    input wire logic                    RST_REGBUS_SYNC_N,
    input wire logic                    RST_MEMBUS_SYNC_N,
    input wire logic                    MODE_CMD,
    input wire logic                    REFRESH_REQ,
    input wire logic                    TASK_VALID,
    input wire logic                    TASK_READY,
    input wire logic [`DCS_X_W-1:0]     TASK_WIDTH,
    input wire logic [1:0]              TASK_COMP,
    input wire logic [`DCS_LAYER_W-1:0] TASK_LAYERS,
    input wire logic [`DCS_X_W-1:0]     TASK_MIN_W,
    input wire logic [`DCS_Y_W-1:0]     TASK_MIN_H,
    input wire logic                    TASK_REJECT,
    input wire logic                    VSYNC,
    input wire logic                    FRAME_BUSY,
    input wire logic                    FRAME_SKIP,
    input wire logic                    BLK_VALID,
    input wire logic                    BLK_READY,
    input wire dcs_pkg::desc_s          BLK_DATA
);
    import dcs_pkg::*;
    logic [3:0] cap;    // layer capacity of the selected compositor
    logic       bad;    // offer that has to be refused
    logic       vid_q;  // a video frame start has been seen
    int         gap_q;  // cycles since the last frame start

    assign cap = (TASK_COMP == `DCS_OV_NARROW_SEL) ? `DCS_OV_CAP_NARROW
                                                   : `DCS_OV_CAP_WIDE;
    assign bad = TASK_LAYERS > cap || TASK_MIN_W < `DCS_MIN_LAYER_X ||
                 TASK_MIN_H < `DCS_MIN_LAYER_Y || TASK_WIDTH == '0;

    // frame gap counter; saturates so a stuck timer cannot wrap back
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            vid_q <= 1'b0;
            gap_q <= 0;
        end else begin
            vid_q <= !MODE_CMD && (vid_q || VSYNC);
            gap_q <= VSYNC ? 1 : (gap_q < 4096 ? gap_q + 1 : gap_q);
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    chk_regbus_release: assert property (
        $rose(RST_REGBUS_N) |-> !RST_REGBUS_SYNC_N [*2])
        else $error("regbus reset released too early");
    chk_membus_release: assert property (
        RST_MEMBUS_N [*3] |-> RST_MEMBUS_SYNC_N)
        else $error("membus reset not released after two edges");
    chk_video_period: assert property (
        vid_q && !MODE_CMD |-> VSYNC == (gap_q == FRAME_CYCLES))
        else $error("video frame start off its period");
    chk_cmd_start: assert property (
        MODE_CMD && REFRESH_REQ && !FRAME_BUSY |=> VSYNC && !FRAME_SKIP)
        else $error("refresh request not answered by frame start");
    chk_busy_skip: assert property (
        MODE_CMD && REFRESH_REQ && FRAME_BUSY |=> FRAME_SKIP && !VSYNC)
        else $error("request while busy not skipped");
    chk_reject_offer: assert property (
        TASK_VALID && TASK_READY && bad |=> TASK_REJECT && TASK_READY)
        else $error("illegal task not refused");
    chk_accept_offer: assert property (
        TASK_VALID && TASK_READY && !bad |=> !TASK_READY && !TASK_REJECT)
        else $error("legal task not taken");
    chk_pending_task: assert property (
        !$past(TASK_READY) |-> TASK_READY == (VSYNC && !FRAME_SKIP))
        else $error("pending task released off a frame start");
    chk_blk_hold: assert property (
        BLK_VALID && !BLK_READY |=> BLK_VALID && $stable(BLK_DATA))
        else $error("descriptor dropped while stalled");
    chk_blk_geom: assert property (
        BLK_VALID && BLK_DATA.offline |-> BLK_DATA.x_base ==
        {BLK_DATA.idx, 9'h000} && (BLK_DATA.last || BLK_DATA.width == 10'h200))
        else $error("offline block geometry wrong");

    cov_video: cover property (vid_q && VSYNC);
    cov_skip: cover property (FRAME_SKIP);
    cov_last: cover property (BLK_VALID && BLK_DATA.offline && BLK_DATA.last);
endmodule

`default_nettype wire

/* verif/blk_sink_model.sv */
// descriptor sink standing in for the read and write-back channels
`timescale 1ns/1ps
`default_nettype none

module blk_sink_model (
    input  wire logic       clk,
    input  wire logic [1:0] mode,
    output logic            ready
);
    initial ready = 1'b0;
    // 0 takes every word, 1 stalls at random, 2 holds off entirely
    always @(posedge clk) begin
        #1;
        ready <= mode == 2'h0 ||
                 (mode == 2'h1 && $urandom_range(0, 1) == 1);
    end
endmodule

`default_nettype wire

/* verif/display_compose_scheduler_tb_top.sv */
// self-checking bench for the compose scheduler
`include "dcs_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module display_compose_scheduler_tb_top;
    import dcs_pkg::*;
    localparam int FC = 200;  // shortened frame period keeps the run short
    logic        clk, nrst, rbn, mbn, rbs, mbs, mode_cmd, req, tv, tr;
    logic        toff, rej, vs, busy, skip, bv, br;
    logic [12:0] tw, minw, cur_w;
    logic [11:0] th, ty0, trows, minh, cur_y0, cur_rows;
    logic [1:0]  tcomp, smode;
    logic [3:0]  tl;
    logic        cur_off;
    desc_s       bd;
    desc_s       exp_q[$];  // descriptors still owed by the design
    int          failures, comparisons, n;

    display_compose_scheduler #(.FRAME_CYCLES(FC))
        display_compose_scheduler_i (
        .REF_CLK(clk), .NRST(nrst), .RST_REGBUS_N(rbn), .RST_MEMBUS_N(mbn),
        .RST_REGBUS_SYNC_N(rbs), .RST_MEMBUS_SYNC_N(mbs), .MODE_CMD(mode_cmd),
        .REFRESH_REQ(req), .TASK_VALID(tv), .TASK_READY(tr), .TASK_WIDTH(tw),
        .TASK_HEIGHT(th), .TASK_Y0(ty0), .TASK_ROWS(trows), .TASK_OFFLINE(toff),
        .TASK_COMP(tcomp), .TASK_LAYERS(tl), .TASK_MIN_W(minw),
        .TASK_MIN_H(minh), .TASK_REJECT(rej), .VSYNC(vs), .FRAME_BUSY(busy),
        .FRAME_SKIP(skip), .BLK_VALID(bv), .BLK_READY(br), .BLK_DATA(bd));
    blk_sink_model blk_sink_model_i (.clk(clk), .mode(smode), .ready(br));

    always #5 clk = ~clk;

    task automatic chk_flag(string what, logic exp, logic got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_desc(string what, desc_s exp, desc_s got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // all stimulus moves a fixed 1 ns after the rising edge
    task automatic tick(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // note the blocks the current task owes for one frame
    task automatic exp_frame();
        desc_s d;
        int    nb;
        nb = cur_off ? (cur_w + 511) / 512 : 1;
        for (int i = 0; i < nb; i++) begin
            d.offline = cur_off;
            d.last    = i == nb - 1;
            d.idx     = 4'(i);
            d.x_base  = cur_off ? 13'(i * 512) : 13'h000;
            d.width   = d.last ? 10'(cur_w - d.x_base) : 10'h200;
            d.y0      = cur_y0;
            d.rows    = cur_rows;
            exp_q.push_back(d);
        end
    endtask

    task automatic offer(logic [12:0] w, logic off, logic [1:0] c,
                         logic [3:0] l, logic [12:0] mw, logic ok);
        // one idle edge keeps back-to-back offers apart
        tick(1);
        {tw, toff, tcomp, tl, minw, minh} = {w, off, c, l, mw, mw[11:0]};
        {ty0, trows, th} = 36'($urandom);
        chk_flag("task_ready", 1'b1, tr);
        tv = 1'b1;
        tick(1);
        tv = 1'b0;
        chk_flag("task_ready", !ok, tr);
        chk_flag("task_reject", !ok, rej);
        if (ok) begin
            {cur_w, cur_off} = {w, off};
            cur_y0   = mode_cmd ? ty0 : 12'h000;
            cur_rows = mode_cmd ? trows : th;
        end
    endtask

    task automatic refresh(logic sk);
        req = 1'b1;
        tick(1);
        req = 1'b0;
        chk_flag("vsync", !sk, vs);
        chk_flag("frame_skip", sk, skip);
        if (!sk) exp_frame();
    endtask

    // bounded wait for every owed block and an idle scheduler
    task automatic drain();
        int k;
        k = 0;
        while ((exp_q.size() != 0 || busy !== 1'b0) && k < 3000) begin
            tick(1);
            k++;
        end
        chk_flag("drained", 1'b1, k < 3000);
        if (k >= 3000) wrap_up();
    endtask

    task automatic wait_vs(output int m);
        m = 0;
        do begin
            tick(1);
            m++;
        end while (vs !== 1'b1 && m < 300);
        chk_flag("vsync_seen", 1'b1, m < 300);
        if (m >= 300) wrap_up();
    endtask

    // monitor: each accepted descriptor is matched to the oldest note
    always @(posedge clk) begin
        if (bv && br)
            chk_desc("blk_data", exp_q.size() ? exp_q.pop_front() : '0,
                     bd);
    end

    initial begin
        {clk, nrst, rbn, mbn, mode_cmd, req, tv, toff} = 8'h08;
        {tw, th, ty0, trows, tcomp, tl, minw, minh, smode} = '0;
        {failures, comparisons} = 0;
        void'($urandom(61528));
        repeat (5) @(posedge clk);
        #1;
        chk_flag("regbus_sync", 1'b0, rbs);
        {nrst, rbn, mbn} = 3'h7;
        tick(1);
        chk_flag("regbus_sync", 1'b0, rbs);
        chk_flag("membus_sync", 1'b0, mbs);
        tick(1);
        chk_flag("regbus_sync", 1'b1, rbs);
        chk_flag("membus_sync", 1'b1, mbs);
        rbn = 1'b0;
        tick(1);
        chk_flag("regbus_sync", 1'b0, rbs);
        chk_flag("membus_sync", 1'b1, mbs);
        rbn = 1'b1;
        tick(2);
        chk_flag("regbus_sync", 1'b1, rbs);
        $display("test resets done");
        // empty width once, then every compositor: over capacity, undersized, then legal
        smode = 2'h1;
        offer(13'h000, 1'b1, 2'h0, 4'h1, 13'h004, 1'b0);
        for (int c = 0; c < 4; c++) begin
            n = c == 3 ? 2 : 8;
            tw = 13'($urandom_range(1, 8191));
            offer(tw, 1'b1, 2'(c), 4'(n + 1), 13'h004, 1'b0);
            offer(tw, 1'b1, 2'(c), 4'(n), 13'h003, 1'b0);
            // offline tasks keep their smallest layer at 16x16
            offer(tw, c[0], 2'(c), 4'(n), c[0] ? 13'h010 : 13'h004,
                  1'b1);
            refresh(1'b0);
            drain();
            refresh(1'b0);
            drain();
        end
        $display("test capacity done");
        // stalled sink: fifo fills, scheduler stalls, request is skipped
        smode = 2'h2;
        offer(13'h1fff, 1'b1, 2'h0, 4'h8, 13'h010,
              1'b1);
        refresh(1'b0);
        tick(40);
        refresh(1'b0);
        tick(40);
        chk_flag("frame_busy", 1'b1, busy);
        refresh(1'b1);
        smode = 2'h1;
        drain();
        $display("test fill done");
        // video screen: fixed period, new task once, then repeats
        smode = 2'h0;
        mode_cmd = 1'b0;
        wait_vs(n);
        exp_frame();
        offer(13'($urandom_range(1, 8191)), 1'b0, 2'h1, 4'h8, 13'h004,
              1'b1);
        for (int f = 0; f < 2; f++) begin
            wait_vs(n);
            // the offer used two cycles of the first measured frame
            chk_flag("frame_gap", 1'b1, n + (f == 0 ? 2 : 0) == FC);
            exp_frame();
        end
        mode_cmd = 1'b1;
        drain();
        $display("test video done");
        wrap_up();
    end
endmodule

bind display_compose_scheduler display_compose_scheduler_asserts #(
    .FRAME_CYCLES(FRAME_CYCLES)
) display_compose_scheduler_asserts_i (
    .REF_CLK(REF_CLK), .NRST(NRST), .RST_REGBUS_N(RST_REGBUS_N),
    .RST_MEMBUS_N(RST_MEMBUS_N), .RST_REGBUS_SYNC_N(RST_REGBUS_SYNC_N),
    .RST_MEMBUS_SYNC_N(RST_MEMBUS_SYNC_N), .MODE_CMD(MODE_CMD),
    .REFRESH_REQ(REFRESH_REQ), .TASK_VALID(TASK_VALID),
    .TASK_READY(TASK_READY), .TASK_WIDTH(TASK_WIDTH), .TASK_COMP(TASK_COMP),
    .TASK_LAYERS(TASK_LAYERS), .TASK_MIN_W(TASK_MIN_W),
    .TASK_MIN_H(TASK_MIN_H), .TASK_REJECT(TASK_REJECT), .VSYNC(VSYNC),
    .FRAME_BUSY(FRAME_BUSY), .FRAME_SKIP(FRAME_SKIP), .BLK_VALID(BLK_VALID),
    .BLK_READY(BLK_READY), .BLK_DATA(BLK_DATA));

`default_nettype wire
